// ---- logic/remap_pkg.sv ----
package remap_pkg;
    // ----------------------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------------------
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 16;
    localparam logic [7:0]  ADDR_OSC_CTRL   = 8'h00;
    localparam logic [7:0]  ADDR_OUT_MAP9   = 8'h04;
    localparam logic [7:0]  ADDR_OUT_MAP10  = 8'h08;
    localparam logic [7:0]  ADDR_IN_MAP0    = 8'h0c;
    localparam logic [7:0]  ADDR_IN_MAP1    = 8'h10;
    localparam logic [7:0]  ADDR_IRQ_STAT   = 8'h14;
    localparam logic [7:0]  ADDR_IRQ_CLR    = 8'h18;
    localparam logic [7:0]  ADDR_IRQ_EN     = 8'h1c;
    localparam logic [7:0]  ADDR_STATUS     = 8'h20;
    // ----------------------------------------------------------------
    // fields
    // ----------------------------------------------------------------
    localparam int          LOCK_BIT        = 6;
    localparam int          ONE_WAY_BIT     = 5;
    localparam int          SEL_W           = 6;
    localparam int          HI_LSB          = 8;
    localparam logic [15:0] FIELD_MASK      = 16'h3f3f;
    localparam logic [15:0] REG_RESET       = 16'h0000;
    localparam logic [7:0]  UNLOCK_KEY1     = 8'h46;
    localparam logic [7:0]  UNLOCK_KEY2     = 8'h57;
    localparam logic [7:0]  CFG_WORD_RESET  = 8'hff;
    localparam int          NUM_PINS        = 4;
    localparam int          NUM_VIRT        = 4;
    localparam logic [5:0]  VIRT_BASE       = 6'h20;
    localparam logic [5:0]  FUNC_NONE       = 6'h00;
    // irq bits
    localparam int          IRQ_MISMATCH    = 0;
    localparam int          IRQ_BLOCKED     = 1;
    localparam int          IRQ_W           = 2;
    // unlock sequencer
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_KEY1 = 2'b01,
        SEQ_OPEN = 2'b10
    } unlock_state_t;
endpackage

// ---- logic/remap_unlock_seq.sv ----
`timescale 1ns/1ns
module remap_unlock_seq (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    input  wire logic clkEn,
    // writes to control low byte, any-write strobe and sequence block
    input  wire logic ctrlWrite,
    input  wire logic [7:0] ctrlData,
    input  wire logic anyWrite,
    input  wire logic sequenceBlocked,
    // sequence result
    output logic      lockChangeOk
);
    import remap_pkg::*;

    unlock_state_t state_reg;
    unlock_state_t state_next;

    // ------------------------------------------------------------
    // key detector
    // ------------------------------------------------------------
    // next state: keys must be back-to-back writes
    always_comb begin
        state_next = state_reg;
        if (anyWrite) begin
            case (state_reg)
                SEQ_IDLE: begin
                    state_next = (ctrlWrite && ctrlData == UNLOCK_KEY1) ? SEQ_KEY1 : SEQ_IDLE;
                end
                SEQ_KEY1: begin
                    state_next = (ctrlWrite && ctrlData == UNLOCK_KEY2) ? SEQ_OPEN : SEQ_IDLE;
                end
                SEQ_OPEN: begin
                    state_next = SEQ_IDLE; // next write consumes the window
                end
                default: begin
                    state_next = SEQ_IDLE;
                end
            endcase
        end
        if (sequenceBlocked) begin
            state_next = SEQ_IDLE;
        end
    end

    // state register
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_reg <= SEQ_IDLE;
        end else if (clkEn) begin
            state_reg <= state_next;
        end
    end

    assign lockChangeOk = (state_reg == SEQ_OPEN);
endmodule // remap_unlock_seq

// ---- logic/remap_pin_select_lock.sv ----
`timescale 1ns/1ns
module remap_pin_select_lock #(
    parameter int NUM_FUNC = 16
) (
    // clock and reset
    input  wire logic                          sys_clk,
    input  wire logic                          sys_rst,
    input  wire logic                          clkEn,
    // register port
    input  wire logic [remap_pkg::ADDR_W-1:0]  regAddr,
    input  wire logic [remap_pkg::DATA_W-1:0]  regWrData,
    input  wire logic                          regWrite,
    input  wire logic                          regRead,
    output logic      [remap_pkg::DATA_W-1:0]  regRdData,
    // configuration word (static fuse bits)
    input  wire logic [7:0]                    oscillatorConfigWord,
    // peripheral outputs, indexed by function number
    input  wire logic [NUM_FUNC-1:0]           periphOut,
    // remappable pin levels from pads 18..21
    input  wire logic [remap_pkg::NUM_PINS-1:0] padIn,
    // pad drive, pins 18..21
    output logic      [remap_pkg::NUM_PINS-1:0] padOut,
    output logic      [remap_pkg::NUM_PINS-1:0] padOe,
    // peripheral inputs, two remapped inputs
    output logic      [1:0]                    periphIn,
    // virtual pin levels, pins 32..35
    output logic      [remap_pkg::NUM_VIRT-1:0] virtualPin,
    // safety and interrupt
    output logic                               mismatchResetReq,
    output logic                               irq
);
    import remap_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [15:0]       outMap9_reg;
    logic [15:0]       outMap10_reg;
    logic [15:0]       inMap0_reg;
    logic [15:0]       inMap1_reg;
    logic [15:0]       shadow9_reg;
    logic [15:0]       shadow10_reg;
    logic [15:0]       shadowIn0_reg;
    logic [15:0]       shadowIn1_reg;
    logic              lock_reg;
    logic              lockEverSet_reg;
    logic              oneWay_reg;
    logic [7:0]        ctrlLow_reg;
    logic [IRQ_W-1:0]  irqStat_reg;
    logic [IRQ_W-1:0]  irqEn_reg;
    logic [IRQ_W-1:0]  irqEvent;
    logic              mismatch_reg;
    logic [NUM_PINS-1:0] padSync1_reg;
    logic [NUM_PINS-1:0] padSync2_reg;
    logic [NUM_PINS-1:0] padOut_reg;
    logic [NUM_VIRT-1:0] virt_reg;
    logic [1:0]        periphIn_reg;
    logic [15:0]       rdData_reg;
    logic              mapWrite;
    logic              ctrlWrite;
    logic              lockChangeOk;
    logic              mismatch;
    logic [SEL_W-1:0]  pinSel [NUM_PINS];
    logic [SEL_W-1:0]  inSel  [2];

    // map register address test, used by decode and lock check
    function automatic logic isMapAddr(input logic [ADDR_W-1:0] a);
        isMapAddr = (a == ADDR_OUT_MAP9) || (a == ADDR_OUT_MAP10) ||
                    (a == ADDR_IN_MAP0) || (a == ADDR_IN_MAP1);
    endfunction

    // level of a 6-bit pin index: pads 18..21 or virtual 32..35
    function automatic logic pinLevel(input logic [SEL_W-1:0] idx,
                                      input logic [NUM_PINS-1:0] pads,
                                      input logic [NUM_VIRT-1:0] virt);
        logic [SEL_W-1:0] off;
        off = idx - VIRT_BASE;
        pinLevel = 1'b0;
        if (idx >= VIRT_BASE && off < SEL_W'(NUM_VIRT)) begin
            pinLevel = virt[off[1:0]];
        end else if (idx >= 6'd18 && idx <= 6'd21) begin
            pinLevel = pads[2'(idx - 6'd18)];
        end
    endfunction

    assign ctrlWrite = regWrite && regAddr == ADDR_OSC_CTRL;
    assign mapWrite  = regWrite && isMapAddr(regAddr) && !lock_reg;

    // ------------------------------------------------------------
    // unlock sequence
    // ------------------------------------------------------------
    remap_unlock_seq u_seq (
        .sys_clk         (sys_clk),
        .sys_rst         (sys_rst),
        .clkEn           (clkEn),
        .ctrlWrite       (ctrlWrite),
        .ctrlData        (regWrData[7:0]),
        .anyWrite        (regWrite),
        .sequenceBlocked (oneWay_reg && lockEverSet_reg),
        .lockChangeOk    (lockChangeOk)
    );

    // config word sampled on every enabled cycle; reset loads the unprogrammed value, which reads one
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            oneWay_reg <= CFG_WORD_RESET[ONE_WAY_BIT];
        end else if (clkEn) begin
            oneWay_reg <= oscillatorConfigWord[ONE_WAY_BIT];
        end
    end

    // mapping write lock, held until explicitly changed
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            lock_reg        <= 1'b0;
            lockEverSet_reg <= 1'b0;
        end else if (clkEn) begin
            if (ctrlWrite && lockChangeOk) begin
                if (!(oneWay_reg && lockEverSet_reg)) begin
                    lock_reg <= regWrData[LOCK_BIT];
                end
                if (regWrData[LOCK_BIT]) begin
                    lockEverSet_reg <= 1'b1;
                end
            end
        end
    end

    // other control low-byte bits are plain storage
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ctrlLow_reg <= 8'h00;
        end else if (clkEn && ctrlWrite && !lockChangeOk) begin
            ctrlLow_reg <= regWrData[7:0];
        end
    end

    // ------------------------------------------------------------
    // map registers and shadows
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            outMap9_reg   <= REG_RESET;
            outMap10_reg  <= REG_RESET;
            inMap0_reg    <= REG_RESET;
            inMap1_reg    <= REG_RESET;
            shadow9_reg   <= REG_RESET;
            shadow10_reg  <= REG_RESET;
            shadowIn0_reg <= REG_RESET;
            shadowIn1_reg <= REG_RESET;
        end else if (clkEn && mapWrite) begin
            case (regAddr)
                ADDR_OUT_MAP9: begin
                    outMap9_reg <= regWrData & FIELD_MASK;
                    shadow9_reg <= regWrData & FIELD_MASK;
                end
                ADDR_OUT_MAP10: begin
                    outMap10_reg <= regWrData & FIELD_MASK;
                    shadow10_reg <= regWrData & FIELD_MASK;
                end
                ADDR_IN_MAP0: begin
                    inMap0_reg    <= regWrData & FIELD_MASK;
                    shadowIn0_reg <= regWrData & FIELD_MASK;
                end
                ADDR_IN_MAP1: begin
                    inMap1_reg    <= regWrData & FIELD_MASK;
                    shadowIn1_reg <= regWrData & FIELD_MASK;
                end
                default: begin
                end
            endcase
        end
    end

    // continuous shadow compare
    assign mismatch = (outMap9_reg != shadow9_reg) || (outMap10_reg != shadow10_reg) ||
                      (inMap0_reg != shadowIn0_reg) || (inMap1_reg != shadowIn1_reg);

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            mismatch_reg <= 1'b0;
        end else if (clkEn) begin
            mismatch_reg <= mismatch;
        end
    end
    assign mismatchResetReq = mismatch_reg;

    // ------------------------------------------------------------
    // pin routing
    // ------------------------------------------------------------
    assign pinSel[0] = outMap9_reg[SEL_W-1:0];
    assign pinSel[1] = outMap9_reg[HI_LSB+SEL_W-1:HI_LSB];
    assign pinSel[2] = outMap10_reg[SEL_W-1:0];
    assign pinSel[3] = outMap10_reg[HI_LSB+SEL_W-1:HI_LSB];
    assign inSel[0]  = inMap0_reg[SEL_W-1:0];
    assign inSel[1]  = inMap0_reg[HI_LSB+SEL_W-1:HI_LSB];

    // pad inputs pass a two-stage synchroniser
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            padSync1_reg <= '0;
            padSync2_reg <= '0;
        end else if (clkEn) begin
            padSync1_reg <= padIn;
            padSync2_reg <= padSync1_reg;
        end
    end

    // pad outputs: selected function level, enable when mapped
    genvar gp;
    generate
        for (gp = 0; gp < NUM_PINS; gp++) begin : g_pad
            always_ff @(posedge sys_clk) begin
                if (sys_rst) begin
                    padOut_reg[gp] <= 1'b0;
                end else if (clkEn) begin
                    padOut_reg[gp] <= (pinSel[gp] != FUNC_NONE && pinSel[gp] < SEL_W'(NUM_FUNC)) ?
                                      periphOut[pinSel[gp][$clog2(NUM_FUNC)-1:0]] : 1'b0;
                end
            end
            assign padOe[gp] = (pinSel[gp] != FUNC_NONE);
        end
    endgenerate
    assign padOut = padOut_reg;

    // virtual pins 0 and 1 use the low selector of input map 1 and the next function, pins 2 and 3 its high selector
    genvar gv;
    generate
        for (gv = 0; gv < NUM_VIRT; gv++) begin : g_virt
            logic [SEL_W-1:0] vsel;
            assign vsel = (gv < 2) ? inMap1_reg[SEL_W-1:0] + SEL_W'(gv) : inMap1_reg[HI_LSB+SEL_W-1:HI_LSB];
            always_ff @(posedge sys_clk) begin
                if (sys_rst) begin
                    virt_reg[gv] <= 1'b0;
                end else if (clkEn) begin
                    virt_reg[gv] <= (vsel != FUNC_NONE && vsel < SEL_W'(NUM_FUNC)) ?
                                    periphOut[vsel[$clog2(NUM_FUNC)-1:0]] : 1'b0;
                end
            end
        end
    endgenerate
    assign virtualPin = virt_reg;

    // peripheral inputs pick a pad or a virtual pin
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            periphIn_reg <= 2'b00;
        end else if (clkEn) begin
            periphIn_reg[0] <= pinLevel(inSel[0], padSync2_reg, virt_reg);
            periphIn_reg[1] <= pinLevel(inSel[1], padSync2_reg, virt_reg);
        end
    end
    assign periphIn = periphIn_reg;

    // ------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------
    assign irqEvent[IRQ_MISMATCH] = mismatch;
    assign irqEvent[IRQ_BLOCKED]  = regWrite && isMapAddr(regAddr) && lock_reg;

    // sticky status, set wins over clear
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            irqStat_reg <= '0;
            irqEn_reg   <= '0;
        end else if (clkEn) begin
            irqStat_reg <= (irqStat_reg & ~((regWrite && regAddr == ADDR_IRQ_CLR) ?
                           regWrData[IRQ_W-1:0] : '0)) | irqEvent;
            if (regWrite && regAddr == ADDR_IRQ_EN) begin
                irqEn_reg <= regWrData[IRQ_W-1:0];
            end
        end
    end
    assign irq = |(irqStat_reg & irqEn_reg);

    // ------------------------------------------------------------
    // read data, one cycle after the strobe
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rdData_reg <= '0;
        end else if (clkEn) begin
            rdData_reg <= '0;
            if (regRead) begin
                case (regAddr)
                    ADDR_OSC_CTRL:  rdData_reg <= {8'h00, ctrlLow_reg & ~(8'h01 << LOCK_BIT)} |
                                                  (16'(lock_reg) << LOCK_BIT);
                    ADDR_OUT_MAP9:  rdData_reg <= outMap9_reg;
                    ADDR_OUT_MAP10: rdData_reg <= outMap10_reg;
                    ADDR_IN_MAP0:   rdData_reg <= inMap0_reg;
                    ADDR_IN_MAP1:   rdData_reg <= inMap1_reg;
                    ADDR_IRQ_STAT:  rdData_reg <= 16'(irqStat_reg);
                    ADDR_IRQ_EN:    rdData_reg <= 16'(irqEn_reg);
                    ADDR_STATUS:    rdData_reg <= {13'h0, oneWay_reg, lockEverSet_reg, lockChangeOk};
                    default:        rdData_reg <= '0;
                endcase
            end
        end
    end
    assign regRdData = rdData_reg;
endmodule // remap_pin_select_lock

// ---- verif/pad_periph_model.sv ----
`timescale 1ns/1ns
module pad_periph_model (
    // peripheral side
    input  wire logic [15:0] funcLevels,
    output logic      [15:0] periphOut,
    // pad side
    input  wire logic [3:0]  padOut,
    input  wire logic [3:0]  padOe,
    output logic      [3:0]  padIn
);
    // peripherals drive the levels the bench commands
    assign periphOut = funcLevels;
    // an undriven pad floats up to its pull-up
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            padIn[i] = padOe[i] ? padOut[i] : 1'b1;
        end
    end
endmodule // pad_periph_model

// ---- verif/remap_pin_select_lock_properties.sv ----
`timescale 1ns/1ns
module remap_pin_select_lock_checker
    import remap_pkg::*;
#(
    parameter int NUM_FUNC = 16
) (
    input wire logic                sys_clk,
    input wire logic                sys_rst,
    input wire logic                clkEn,
    input wire logic [ADDR_W-1:0]   regAddr,
    input wire logic [DATA_W-1:0]   regWrData,
    input wire logic                regWrite,
    input wire logic                regRead,
    input wire logic [DATA_W-1:0]   regRdData,
    input wire logic [7:0]          oscillatorConfigWord,
    input wire logic [NUM_FUNC-1:0] periphOut,
    input wire logic [NUM_PINS-1:0] padIn,
    input wire logic [NUM_PINS-1:0] padOut,
    input wire logic [NUM_PINS-1:0] padOe,
    input wire logic [1:0]          periphIn,
    input wire logic [NUM_VIRT-1:0] virtualPin,
    input wire logic                mismatchResetReq,
    input wire logic                irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // -------------------------------------------------------------
    // shadow of key sequence, lock and interrupt enable
    // -------------------------------------------------------------
    logic [1:0] keyState;
    logic       lockShadow;
    logic [1:0] irqEnShadow;
    wire        wrOk   = clkEn && regWrite;
    wire        ctrlWr = wrOk && (regAddr == ADDR_OSC_CTRL);
    wire        mapWr  = wrOk && (regAddr == ADDR_OUT_MAP9 || regAddr == ADDR_OUT_MAP10);
    // key tracking restarts on any other write
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            keyState <= 2'h0;
        end else if (wrOk) begin
            if (ctrlWr && keyState == 2'h0 && regWrData[7:0] == UNLOCK_KEY1) begin
                keyState <= 2'h1;
            end else if (ctrlWr && keyState == 2'h1 && regWrData[7:0] == UNLOCK_KEY2) begin
                keyState <= 2'h2;
            end else begin
                keyState <= 2'h0;
            end
        end
    end
    // lock follows the write that closes the sequence
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            lockShadow <= 1'b0;
        end else if (ctrlWr && keyState == 2'h2 && !(oscillatorConfigWord[ONE_WAY_BIT] && lockShadow)) begin
            lockShadow <= regWrData[LOCK_BIT];
        end
    end
    // interrupt enable copy
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            irqEnShadow <= 2'h0;
        end else if (wrOk && regAddr == ADDR_IRQ_EN) begin
            irqEnShadow <= regWrData[1:0];
        end
    end
    // -------------------------------------------------------------
    // properties
    // -------------------------------------------------------------
    property p_map_reserved;
        $past(regRead) && ($past(regAddr) == ADDR_OUT_MAP9 || $past(regAddr) == ADDR_OUT_MAP10) |->
            (regRdData & ~FIELD_MASK) == 16'h0000;
    endproperty
    a_map_reserved: assert property (p_map_reserved) else $error("map reserved bits not zero");
    property p_lock_read;
        $past(regRead) && $past(regAddr) == ADDR_OSC_CTRL |-> regRdData[LOCK_BIT] == $past(lockShadow);
    endproperty
    a_lock_read: assert property (p_lock_read) else $error("lock bit reads wrong");
    property p_locked_hold;
        lockShadow && mapWr |=> $stable(padOe);
    endproperty
    a_locked_hold: assert property (p_locked_hold) else $error("locked write changed map");
    property p_map9_oe;
        !lockShadow && wrOk && regAddr == ADDR_OUT_MAP9 |=>
            padOe[1:0] == {$past(regWrData[13:8]) != 6'h00, $past(regWrData[5:0]) != 6'h00};
    endproperty
    a_map9_oe: assert property (p_map9_oe) else $error("pins 18/19 enable wrong");
    property p_map10_oe;
        !lockShadow && wrOk && regAddr == ADDR_OUT_MAP10 |=>
            padOe[3:2] == {$past(regWrData[13:8]) != 6'h00, $past(regWrData[5:0]) != 6'h00};
    endproperty
    a_map10_oe: assert property (p_map10_oe) else $error("pins 20/21 enable wrong");
    property p_blocked_irq;
        lockShadow && mapWr && irqEnShadow[IRQ_BLOCKED] |-> ##[1:2] irq;
    endproperty
    a_blocked_irq: assert property (p_blocked_irq) else $error("blocked write raised no interrupt");
    property p_irq_clear;
        wrOk && regAddr == ADDR_IRQ_CLR && regWrData[1:0] == 2'h3 |-> ##[1:2] !irq;
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("interrupt stays after clear");
    property p_no_mismatch;
        !mismatchResetReq;
    endproperty
    a_no_mismatch: assert property (p_no_mismatch) else $error("mismatch reset without disturbance");
endmodule // remap_pin_select_lock_checker
bind remap_pin_select_lock remap_pin_select_lock_checker #(.NUM_FUNC(NUM_FUNC)) i_remap_pin_select_lock_checker (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .clkEn(clkEn), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .oscillatorConfigWord(oscillatorConfigWord),
    .periphOut(periphOut), .padIn(padIn), .padOut(padOut), .padOe(padOe), .periphIn(periphIn),
    .virtualPin(virtualPin), .mismatchResetReq(mismatchResetReq), .irq(irq));

// ---- verif/remap_pin_select_lock_tb.sv ----
`timescale 1ns/1ns
module remap_pin_select_lock_tb;
    import remap_pkg::*;
    logic        sys_clk    = 1'b0;
    logic        sys_rst    = 1'b1;
    logic        clkEn      = 1'b1;
    logic [7:0]  regAddr    = 8'h00;
    logic [15:0] regWrData  = 16'h0000;
    logic        regWrite   = 1'b0;
    logic        regRead    = 1'b0;
    logic [7:0]  cfgWord    = 8'hdf;
    logic [15:0] funcLevels = 16'ha5c3;
    logic [15:0] regRdData, periphOut;
    logic [3:0]  padIn, padOut, padOe, virtualPin;
    logic [1:0]  periphIn;
    logic        mismatchResetReq, irq;
    int          n_errors   = 0;
    int          n_compared = 0;
    always #2 sys_clk = ~sys_clk;
    remap_pin_select_lock #(.NUM_FUNC(16)) i_remap_pin_select_lock (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .clkEn(clkEn), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .oscillatorConfigWord(cfgWord),
        .periphOut(periphOut), .padIn(padIn), .padOut(padOut), .padOe(padOe), .periphIn(periphIn),
        .virtualPin(virtualPin), .mismatchResetReq(mismatchResetReq), .irq(irq));
    pad_periph_model i_pad_periph_model (
        .funcLevels(funcLevels), .periphOut(periphOut), .padOut(padOut), .padOe(padOe), .padIn(padIn));
    // -------------------------------------------------------------
    // tasks
    // -------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] expected);
        n_compared++;
        if (seen !== expected) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, expected);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge sys_clk);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
        @(posedge sys_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge sys_clk);
        regRead <= 1'b0;
        #1;
        check(regRdData & m, e);
    endtask
    // both keys then the lock value, optionally cut by another write
    task automatic unlock(input logic [15:0] d, input logic cut);
        @(posedge sys_clk);
        regWrite <= 1'b1;
        regAddr <= ADDR_OSC_CTRL;
        regWrData <= {8'h00, UNLOCK_KEY1};
        if (cut) begin
            @(posedge sys_clk);
            regAddr <= ADDR_IRQ_EN;
            regWrData <= 16'h0000;
        end
        @(posedge sys_clk);
        regAddr <= ADDR_OSC_CTRL;
        regWrData <= {8'h00, UNLOCK_KEY2};
        @(posedge sys_clk);
        regWrData <= d;
        @(posedge sys_clk);
        regWrite <= 1'b0;
    endtask
    task automatic do_reset;
        @(posedge sys_clk);
        sys_rst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'b0;
    endtask
    task automatic stop_test;
        $display("compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // -------------------------------------------------------------
    // tests
    // -------------------------------------------------------------
    initial begin
        repeat (12) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rd(ADDR_OUT_MAP9, 16'hffff, REG_RESET);
        rd(ADDR_OUT_MAP10, 16'hffff, REG_RESET);
        rd(ADDR_OSC_CTRL, 16'h0040, 16'h0000);
        rd(8'hfc, 16'hffff, 16'h0000);
        wr(ADDR_OUT_MAP9, 16'hffff);
        rd(ADDR_OUT_MAP9, 16'hffff, FIELD_MASK);
        wr(ADDR_OUT_MAP10, 16'hc0ff);
        rd(ADDR_OUT_MAP10, 16'hffff, 16'h003f);
        // pin19 takes 3, pin18 takes 6, pin21 takes 7, virtual pins from 4, 5 and 9, inputs from 32 and 20
        wr(ADDR_OUT_MAP9, 16'h0306);
        wr(ADDR_OUT_MAP10, 16'h0700);
        wr(ADDR_IN_MAP1, 16'h0904);
        wr(ADDR_IN_MAP0, 16'h1420);
        for (int k = 0; k < 2; k++) begin
            @(posedge sys_clk);
            funcLevels <= (k == 0) ? 16'ha5c3 : 16'h5a3c;
            repeat (8) @(posedge sys_clk);
            #1;
            check({12'h000, padOe}, 16'h000b);
            check({12'h000, padOut}, {12'h000, funcLevels[7], 1'b0, funcLevels[3], funcLevels[6]});
            check({12'h000, virtualPin}, {12'h000, funcLevels[9], funcLevels[9], funcLevels[5:4]});
            check({14'h0000, periphIn}, {14'h0000, 1'b1, funcLevels[4]});
            check({15'h0000, mismatchResetReq}, 16'h0000);
        end
        wr(ADDR_OSC_CTRL, 16'h0040);
        rd(ADDR_OSC_CTRL, 16'h0040, 16'h0000);
        unlock(16'h0040, 1'b1);
        rd(ADDR_OSC_CTRL, 16'h0040, 16'h0000);
        unlock(16'h0040, 1'b0);
        rd(ADDR_OSC_CTRL, 16'h0040, 16'h0040);
        wr(ADDR_IRQ_EN, 16'h0002);
        wr(ADDR_OUT_MAP9, 16'h0000);
        rd(ADDR_OUT_MAP9, 16'hffff, 16'h0306);
        rd(ADDR_IRQ_STAT, 16'h0003, 16'h0002);
        check({15'h0000, irq}, 16'h0001);
        wr(ADDR_IRQ_CLR, 16'h0003);
        rd(ADDR_IRQ_STAT, 16'h0003, 16'h0000);
        wr(ADDR_IRQ_EN, 16'h0000);
        wr(ADDR_OUT_MAP10, 16'h0000);
        rd(ADDR_OUT_MAP10, 16'hffff, 16'h0700);
        rd(ADDR_IRQ_STAT, 16'h0003, 16'h0002);
        check({15'h0000, irq}, 16'h0000);
        wr(ADDR_IRQ_CLR, 16'h0003);
        repeat (50) @(posedge sys_clk);
        rd(ADDR_OSC_CTRL, 16'h0040, 16'h0040);
        // option programmed: repeated sessions
        for (int s = 0; s < 2; s++) begin
            unlock(16'h0000, 1'b0);
            rd(ADDR_OSC_CTRL, 16'h0040, 16'h0000);
            unlock(16'h0040, 1'b0);
            rd(ADDR_OSC_CTRL, 16'h0040, 16'h0040);
        end
        // option unprogrammed: one session only
        @(posedge sys_clk);
        cfgWord <= CFG_WORD_RESET;
        do_reset();
        rd(ADDR_STATUS, 16'h0004, 16'h0004);
        unlock(16'h0040, 1'b0);
        rd(ADDR_OSC_CTRL, 16'h0040, 16'h0040);
        unlock(16'h0000, 1'b0);
        rd(ADDR_OSC_CTRL, 16'h0040, 16'h0040);
        wr(ADDR_OUT_MAP9, 16'h0102);
        rd(ADDR_OUT_MAP9, 16'hffff, 16'h0000);
        do_reset();
        rd(ADDR_OSC_CTRL, 16'h0040, 16'h0000);
        wr(ADDR_OUT_MAP9, 16'h0102);
        rd(ADDR_OUT_MAP9, 16'hffff, 16'h0102);
        // a write while the clock enable is low must leave state frozen
        @(posedge sys_clk);
        clkEn <= 1'b0;
        wr(ADDR_OUT_MAP9, 16'h0203);
        clkEn <= 1'b1;
        rd(ADDR_OUT_MAP9, 16'hffff, 16'h0102);
        check({15'h0000, mismatchResetReq}, 16'h0000);
        stop_test();
    end
    // watchdog
    initial begin
        #20000;
        n_errors++;
        stop_test();
    end
endmodule // remap_pin_select_lock_tb
